// ==== verilog/pca_params.svh ====
`ifndef PCA_PARAMS_SVH
`define PCA_PARAMS_SVH
// Register addresses on the plain port.
`define PCA_ADDR_CTRL      8'h00
`define PCA_ADDR_MODE      8'h01
`define PCA_ADDR_CNT_LO    8'h02
`define PCA_ADDR_CNT_HI    8'h03
`define PCA_ADDR_MODREG0   8'h04
`define PCA_ADDR_CMP_LO0   8'h05
`define PCA_ADDR_CMP_HI0   8'h06
`define PCA_MOD_STRIDE     8'h03
// Control register fields.
`define PCA_CTRL_RUN       6
`define PCA_CTRL_OVF       7
// Array mode register fields.
`define PCA_MD_OVF_IE      0
`define PCA_MD_TB_LSB      1
`define PCA_MD_IDLE        7
`define PCA_MD_WDOG        6
`define PCA_MD_RESET       8'h40
// Module mode register fields.
`define PCA_MM_IE          0
`define PCA_MM_PWM         1
`define PCA_MM_TOG         2
`define PCA_MM_MAT         3
`define PCA_MM_CAPN        4
`define PCA_MM_CAPP        5
`define PCA_MM_ECOM        6
`define PCA_MM_WIDE        7
// Timebase dividers.
`define PCA_DIV12          4'd12
`define PCA_DIV4           4'd4
`define PCA_EXT_DIV        3'd7
`endif

// ==== verilog/pca_pkg.sv ====
package pca_pkg;
   typedef enum logic [2:0] {
      PCA_TB_DIV12, PCA_TB_DIV4, PCA_TB_T0, PCA_TB_ECI,
      PCA_TB_SYS, PCA_TB_EXT8, PCA_TB_RSV6, PCA_TB_RSV7
   } pca_tb_e;
   typedef enum {
      PCA_M_CAPTURE, PCA_M_TIMER, PCA_M_HSO, PCA_M_FREQ,
      PCA_M_PWM8, PCA_M_PWM16, PCA_M_NONE
   } pca_mode_e;
endpackage

// ==== verilog/pca_top.sv ====
// Functional notes
// RQ1 - Counter wrap from all ones to zero sets the overflow flag.
// RQ2 - Low byte read latches high byte; next high read returns the latch.
// RQ3 - Byte reads never disturb counting.
// RQ4 - Software reads low byte before high byte for a coherent value.
// RQ5 - Timebase select picks div12, div4, timer0, count input, sysclk, ext/8.
// RQ6 - Count input toggles no faster than a quarter of the system clock.
// RQ7 - External oscillator div8 tick is synchronised to the system clock.
// RQ8 - Overflow flag requests interrupt only while its enable is set.
// RQ9 - Overflow flag is never cleared by hardware; software writes zero.
// RQ10 - With idle suspend clear, the array runs during processor idle.
// RQ11 - Four event flags set on their trigger regardless of enables.
// RQ12 - Interrupt request is OR of each flag gated by its own enable.
// RQ13 - Processor needs global and array enables to take the interrupt.
// RQ14 - Three modules, each with 16-bit register, own pin, six modes.
// RQ15 - Module mode bit 0 enables that module flag onto the interrupt.
// RQ16 - Capture: bits 3..1 zero; bit 5 rising, bit 4 falling, both any.
// RQ17 - Compare modes decode timer, high-speed, frequency, 8 or 16-bit PWM.
// RQ18 - Comparator off when bit 6 clear: no toggles, PWM output low.
// RQ19 - In PWM modes with bit 3 set each match sets the module flag.
// RQ20 - Module 2 starts in watchdog operation; some writes are restricted.
// RQ21 - Capture edge copies counter into module register and sets flag.
// RQ22 - Compare low write clears comparator enable; high write sets it.
// RQ23 - 8-bit PWM reloads compare low from high when counter low wraps.
// RQ24 - Frequency mode low match toggles pin and adds high into low.
// RQ25 - Reserved timebase codes stop the counter.
// RQ26 - Idle suspend set and processor idle holds the counter.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pca_params.svh"
module pca_top
   import pca_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rdata,
   input  wire logic        cpu_idle,
   input  wire logic        timer0_ovf,
   input  wire logic        external_count_input,
   input  wire logic        ext_osc_clk,
   input  wire logic [2:0]  module_pin_in,
   output logic      [2:0]  module_pin_out,
   output logic      [2:0]  module_pin_oe,
   output logic             watchdog_function,
   output logic             irq
);
   function automatic pca_mode_e decode_mode(input logic [7:0] m);
      if (m[3:1] == 3'b000)
         decode_mode = PCA_M_CAPTURE;
      else if (m[3:1] == 3'b100)
         decode_mode = PCA_M_TIMER;
      else if (m[3:1] == 3'b110)
         decode_mode = PCA_M_HSO;
      else if (m[2:1] == 2'b11 && !m[3])
         decode_mode = PCA_M_FREQ;
      else if (m[2:1] == 2'b01)
         decode_mode = m[7] ? PCA_M_PWM16 : PCA_M_PWM8;
      else
         decode_mode = PCA_M_NONE;
   endfunction

   logic [7:0]  md_q;
   logic        run_q;
   logic        ovf_q;
   logic [15:0] cnt_q;
   logic [7:0]  snap_q;
   logic [3:0]  pre_q;
   logic [2:0]  eci_sync_q;
   logic [2:0]  ext_sync_q;
   logic [2:0]  ext_div_q;
   logic        ext_tick_q;
   logic [7:0]  rdata_q;
   logic [7:0]  mm_q   [3];
   logic [15:0] ccr_q  [3];
   logic [2:0]  flag_q;
   logic [2:0]  pout_q;
   logic [2:0]  pin_s1_q;
   logic [2:0]  pin_s2_q;
   logic [2:0]  pin_s3_q;

   // The external oscillator is divided in its own domain and only its
   // toggling output crosses, so no multi-bit value leaves that domain.
   always_ff @(posedge ext_osc_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_div_q  <= 3'h0;
         ext_tick_q <= 1'b0;
      end else begin
         ext_div_q <= ext_div_q + 3'h1;
         if (ext_div_q == 3'h3 || ext_div_q == `PCA_EXT_DIV)
            ext_tick_q <= ~ext_tick_q;
      end
   end

   // Every pin input passes two flops before any edge logic reads it; the
   // third stage only serves as the previous sample for edge detection.
   // A capture therefore lands two to three cycles after the pin moves, and
   // a pulse shorter than one system clock may be missed entirely.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         eci_sync_q <= 3'h0;
         ext_sync_q <= 3'h0;
         pin_s1_q   <= 3'h0;
         pin_s2_q   <= 3'h0;
         pin_s3_q   <= 3'h0;
      end else begin
         eci_sync_q <= {eci_sync_q[1:0], external_count_input};
         ext_sync_q <= {ext_sync_q[1:0], ext_tick_q}; // RQ7
         pin_s1_q   <= module_pin_in;
         pin_s2_q   <= pin_s1_q;
         pin_s3_q   <= pin_s2_q;
      end
   end

   // The prescaler is shared by the divide-by-12 and divide-by-4 bases.
   // It is held at zero for every other base so that switching back to a
   // divided base always starts a full period rather than a partial one.
   // Reserved timebase codes produce no tick at all, so the count freezes.
   pca_tb_e tb;
   assign tb = pca_tb_e'(md_q[`PCA_MD_TB_LSB +: 3]);
   wire pre_wrap   = (tb == PCA_TB_DIV12) ? (pre_q == `PCA_DIV12 - 4'd1)
                                          : (pre_q == `PCA_DIV4 - 4'd1);
   wire eci_fall   = eci_sync_q[2] & ~eci_sync_q[1];
   wire ext_fall   = ext_sync_q[2] & ~ext_sync_q[1];
   wire suspended  = md_q[`PCA_MD_IDLE] & cpu_idle; // RQ10 RQ26
   logic tb_tick;
   always_comb begin
      case (tb) // RQ5
         PCA_TB_DIV12: tb_tick = pre_wrap;
         PCA_TB_DIV4:  tb_tick = pre_wrap;
         PCA_TB_T0:    tb_tick = timer0_ovf;
         PCA_TB_ECI:   tb_tick = eci_fall;
         PCA_TB_SYS:   tb_tick = 1'b1;
         PCA_TB_EXT8:  tb_tick = ext_fall;
         default:      tb_tick = 1'b0; // RQ25
      endcase
   end
   // All advance sources meet here; run, idle suspend and timebase gate
   // one common enable, which keeps every module in step with the counter.
   wire adv       = tb_tick & run_q & ~suspended;
   wire cnt_wrap  = adv & (cnt_q == 16'hFFFF);
   wire lo_wrap   = adv & (cnt_q[7:0] == 8'hFF);

   // Register decode.
   wire wr_ctrl   = wr_en & (addr == `PCA_ADDR_CTRL);
   wire wr_md     = wr_en & (addr == `PCA_ADDR_MODE);
   wire rd_lo     = rd_en & (addr == `PCA_ADDR_CNT_LO);
   logic [2:0] wr_mm;
   logic [2:0] wr_cl;
   logic [2:0] wr_ch;
   logic [2:0] cap_ev;
   logic [2:0] match_ev;
   logic [2:0] set_flag;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_dec
         localparam logic [7:0] BASE = `PCA_ADDR_MODREG0
                                       + 8'(g) * `PCA_MOD_STRIDE;
         assign wr_mm[g] = wr_en & (addr == BASE);
         assign wr_cl[g] = wr_en & (addr == BASE + 8'h01);
         assign wr_ch[g] = wr_en & (addr == BASE + 8'h02);
      end
   endgenerate

   // Watchdog operation blocks changes to the array mode register.
   // Only the watchdog bit stays writable while that function is active, so
   // software must clear it first before choosing a timebase or idle policy.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         md_q <= `PCA_MD_RESET; // RQ20
      end else if (wr_md && !md_q[`PCA_MD_WDOG]) begin
         md_q <= wdata;
      end else if (wr_md) begin
         md_q <= {md_q[7], wdata[`PCA_MD_WDOG], md_q[5:0]}; // RQ20
      end
   end
   assign watchdog_function = md_q[`PCA_MD_WDOG];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (wr_ctrl)
            run_q <= wdata[`PCA_CTRL_RUN];
         // The set wins over a clear in the same cycle.
         if (cnt_wrap) // RQ1 RQ11
            ovf_q <= 1'b1;
         else if (wr_ctrl) // RQ9
            ovf_q <= wdata[`PCA_CTRL_OVF];
      end
   end

   // Software writes to the counter take priority over an advance in the
   // same cycle; the written value is what the next tick increments.
   // The high byte snapshot is taken on the read strobe itself, so a read of
   // the high byte in the very next cycle already sees the latched copy.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_q  <= 4'h0;
         cnt_q  <= 16'h0000;
         snap_q <= 8'h00;
      end else begin
         if (!run_q || suspended || pre_wrap || tb > PCA_TB_DIV4)
            pre_q <= 4'h0;
         else
            pre_q <= pre_q + 4'h1;
         if (wr_en && addr == `PCA_ADDR_CNT_LO)
            cnt_q <= {cnt_q[15:8], wdata};
         else if (wr_en && addr == `PCA_ADDR_CNT_HI)
            cnt_q <= {wdata, cnt_q[7:0]};
         else if (adv) // RQ3
            cnt_q <= cnt_q + 16'h0001;
         if (rd_lo) // RQ2
            snap_q <= cnt_q[15:8];
      end
   end

   generate
      // Matches compare against the value the counter is about to take, so
      // the event, pin change and flag all coincide with the counter reaching
      // the compare value instead of trailing it by one cycle.
      for (g = 0; g < 3; g++) begin : g_mod // RQ14
         pca_mode_e mode;
         assign mode = decode_mode(mm_q[g]); // RQ17
         wire ecom  = mm_q[g][`PCA_MM_ECOM];
         wire rise  = pin_s2_q[g] & ~pin_s3_q[g];
         wire fall  = ~pin_s2_q[g] & pin_s3_q[g];
         // RQ16
         assign cap_ev[g] = (mode == PCA_M_CAPTURE) &
                            ((mm_q[g][`PCA_MM_CAPP] & rise) |
                             (mm_q[g][`PCA_MM_CAPN] & fall));
         wire m16  = ecom & adv & (cnt_q + 16'h0001 == ccr_q[g]);
         wire m8   = ecom & adv & (cnt_q[7:0] + 8'h01 == ccr_q[g][7:0]);
         wire pwm  = (mode == PCA_M_PWM8) | (mode == PCA_M_PWM16);
         wire pm   = (mode == PCA_M_PWM8) ? m8 : m16;
         assign match_ev[g] = mm_q[g][`PCA_MM_MAT] &
                              (((mode == PCA_M_TIMER ||
                                 mode == PCA_M_HSO ||
                                 mode == PCA_M_FREQ) & m16) |
                               (pwm & pm)); // RQ19
         assign set_flag[g] = cap_ev[g] | match_ev[g]; // RQ11
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               mm_q[g]   <= 8'h00;
               ccr_q[g]  <= 16'h0000;
               pout_q[g] <= 1'b0;
            end else begin
               if (wr_mm[g])
                  mm_q[g] <= wdata;
               else if (wr_cl[g])
                  mm_q[g][`PCA_MM_ECOM] <= 1'b0; // RQ22
               else if (wr_ch[g])
                  mm_q[g][`PCA_MM_ECOM] <= 1'b1; // RQ22
               if (wr_cl[g])
                  ccr_q[g][7:0] <= wdata;
               else if (wr_ch[g])
                  ccr_q[g][15:8] <= wdata;
               else if (cap_ev[g])
                  ccr_q[g] <= cnt_q; // RQ21
               else if (mode == PCA_M_PWM8 && lo_wrap)
                  ccr_q[g][7:0] <= ccr_q[g][15:8]; // RQ23
               else if (mode == PCA_M_FREQ && m8)
                  ccr_q[g][7:0] <= ccr_q[g][7:0] + ccr_q[g][15:8]; // RQ24
               // RQ18
               if (mode == PCA_M_HSO && m16)
                  pout_q[g] <= ~pout_q[g];
               else if (mode == PCA_M_FREQ && m8) // RQ24
                  pout_q[g] <= ~pout_q[g];
               else if (pwm && !ecom)
                  pout_q[g] <= 1'b0;
               else if (pwm && pm)
                  pout_q[g] <= 1'b1;
               else if (mode == PCA_M_PWM8 && lo_wrap)
                  pout_q[g] <= 1'b0;
               else if (mode == PCA_M_PWM16 && cnt_wrap)
                  pout_q[g] <= 1'b0;
            end
         end
         assign module_pin_oe[g] = (mode != PCA_M_CAPTURE) &
                                   (mode != PCA_M_TIMER) &
                                   (mode != PCA_M_NONE);
      end
   endgenerate
   assign module_pin_out = pout_q;

   // A hardware event outranks a software clear arriving in the same cycle,
   // so no event is ever lost between servicing and clearing a flag.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (set_flag[i]) // RQ11
               flag_q[i] <= 1'b1;
            else if (wr_ctrl)
               flag_q[i] <= wdata[i];
         end
      end
   end

   // RQ8 RQ12 RQ15
   assign irq = (ovf_q & md_q[`PCA_MD_OVF_IE]) |
                (flag_q[0] & mm_q[0][`PCA_MM_IE]) |
                (flag_q[1] & mm_q[1][`PCA_MM_IE]) |
                (flag_q[2] & mm_q[2][`PCA_MM_IE]);

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (addr)
         `PCA_ADDR_CTRL:    rd_mux = {ovf_q, run_q, 3'h0, flag_q};
         `PCA_ADDR_MODE:    rd_mux = md_q;
         `PCA_ADDR_CNT_LO:  rd_mux = cnt_q[7:0];
         `PCA_ADDR_CNT_HI:  rd_mux = snap_q; // RQ2
         8'h04:             rd_mux = mm_q[0];
         8'h05:             rd_mux = ccr_q[0][7:0];
         8'h06:             rd_mux = ccr_q[0][15:8];
         8'h07:             rd_mux = mm_q[1];
         8'h08:             rd_mux = ccr_q[1][7:0];
         8'h09:             rd_mux = ccr_q[1][15:8];
         8'h0A:             rd_mux = mm_q[2];
         8'h0B:             rd_mux = ccr_q[2][7:0];
         8'h0C:             rd_mux = ccr_q[2][15:8];
         default:           rd_mux = 8'h00;
      endcase
   end

   // Read data stand for one cycle only and return to zero afterwards, which
   // keeps an idle bus from echoing stale register contents.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         rdata_q <= 8'h00;
      else if (rd_en)
         rdata_q <= rd_mux;
      else
         rdata_q <= 8'h00;
   end
   assign rdata = rdata_q;
endmodule // pca_top
`default_nettype wire

// ==== test/pca_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pca_pin_model (
   input  wire logic       clock,
   input  wire logic [2:0] pin_level,
   input  wire logic [2:0] module_pin_out,
   input  wire logic [2:0] module_pin_oe,
   output var  logic [2:0] module_pin_in,
   output var  logic       external_count_input,
   output var  logic       timer0_ovf,
   output var  logic       ext_osc_clk
);
   logic [2:0] div_q;
   initial begin
      div_q = 3'h0;
      timer0_ovf = 1'b0;
      external_count_input = 1'b0;
      ext_osc_clk = 1'b0;
   end
   // The oscillator runs free and unrelated to the system clock.
   always #35 ext_osc_clk = ~ext_osc_clk;
   // A pin the block drives reads back its own level.
   assign module_pin_in = (module_pin_oe & module_pin_out)
                        | (~module_pin_oe & pin_level);
   always @(posedge clock) begin
      div_q <= div_q + 3'h1;
      timer0_ovf <= (div_q == 3'h5);
      // One falling edge every eight cycles stays under a quarter rate.
      external_count_input <= div_q[2];
   end
endmodule // pca_pin_model
`default_nettype wire

// ==== test/pca_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module pca_checker (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rdata,
   input wire logic [2:0] module_pin_out,
   input wire logic [2:0] module_pin_oe,
   input wire logic       watchdog_function,
   input wire logic       irq
);
   logic [7:0] mm_q [3];
   logic       oie_q;
   logic [2:0] oe_x;
   logic [2:0] off_x;
   logic       no_ie;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Shadow copies of the mode bits, taken from the writes, with the overflow enable gated by the watchdog output.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mm_q <= '{default: 8'h00};
         oie_q <= 1'b0;
      end else if (wr_en) begin
         if (addr == 8'h01 && !watchdog_function) oie_q <= wdata[0];
         for (int i = 0; i < 3; i++) begin
            if (addr == 8'h04 + 3 * i) mm_q[i] <= wdata;
            if (addr == 8'h05 + 3 * i) mm_q[i][6] <= 1'b0;
            if (addr == 8'h06 + 3 * i) mm_q[i][6] <= 1'b1;
         end
      end
   end
   for (genvar g = 0; g < 3; g++) begin : g_dec
      assign oe_x[g] = mm_q[g][3:1] == 3'b110 || mm_q[g][3:1] == 3'b011
                       || mm_q[g][2:1] == 2'b01;
      assign off_x[g] = mm_q[g][2:1] == 2'b01 && !mm_q[g][6];
   end
   assign no_ie = !oie_q && !mm_q[0][0] && !mm_q[1][0] && !mm_q[2][0];
   unmap_read_a: assert property (rd_en && addr > 8'h0C |=> rdata == 8'h00)
      else $error("unmapped read gave nonzero data");
   wdog_reset_a: assert property ($rose(rst_n) |-> watchdog_function)
      else $error("watchdog not active after reset");
   wdog_write_a: assert property (wr_en && addr == 8'h01 |=>
      watchdog_function == $past(wdata[6]))
      else $error("watchdog bit did not follow the write");
   wdog_hold_a: assert property (!(wr_en && addr == 8'h01) |=>
      $stable(watchdog_function)) else $error("watchdog bit changed alone");
   pin_oe_a: assert property ($stable(oe_x) && oe_x == $past(oe_x, 2)
      |-> module_pin_oe == oe_x) else $error("pin enable wrong for mode");
   pwm_low_a: assert property ((off_x & $past(off_x) & $past(off_x, 2)
      & module_pin_out) == 3'h0) else $error("pwm pin high with comparator off");
   irq_gate_a: assert property (no_ie && $past(no_ie) |-> !irq)
      else $error("request raised with all enables clear");
   ecom_track_a: assert property (rd_en && addr == 8'h07 |=>
      rdata == mm_q[1]) else $error("module mode readback wrong");
   cover property ($rose(irq));
   cover property ($rose(module_pin_out[2]));
   cover property ($fell(watchdog_function));
endmodule // pca_checker
bind pca_top pca_checker u_chk (.clock, .rst_n, .addr, .wdata, .wr_en,
   .rd_en, .rdata, .module_pin_out, .module_pin_oe, .watchdog_function, .irq);
`default_nettype wire

// ==== test/tb_counter_array_capture_compare.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_counter_array_capture_compare;
   typedef struct {logic [7:0] a, w, x;} pca_row_s;
   logic       clock, rst_n, wr_en, rd_en, cpu_idle, irq;
   logic [7:0] addr, wdata, rdata, d, e;
   logic [2:0] pin_level, module_pin_in, module_pin_out, module_pin_oe;
   logic       timer0_ovf, external_count_input, ext_osc_clk;
   logic       watchdog_function;
   logic       global_irq_enable = 1'b1;
   logic       array_irq_enable = 1'b1;
   int         err_total, checks_done, cyc;
   int         tb_n [6] = '{8, 24, 12, 12, 96, 3};
   pca_row_s   rows [6] = '{'{8'h01, 8'h0E, 8'h00}, '{8'h01, 8'h0E, 8'h0E},
      '{8'h04, 8'h31, 8'h31}, '{8'h07, 8'h01, 8'h01},
      '{8'h0A, 8'h40, 8'h40}, '{8'h0D, 8'h55, 8'h00}};
   pca_top DUT (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
      .cpu_idle, .timer0_ovf, .external_count_input, .ext_osc_clk,
      .module_pin_in, .module_pin_out, .module_pin_oe, .watchdog_function,
      .irq);
   pca_pin_model u_pins (.clock, .pin_level, .module_pin_out, .module_pin_oe,
      .module_pin_in, .external_count_input, .timer0_ovf, .ext_osc_clk);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge clock);
      {wr_en, addr, wdata} <= {1'b1, a, w};
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge clock);
      {rd_en, addr} <= {1'b1, a};
      @(posedge clock);
      rd_en <= 1'b0;
      @(negedge clock);
      r = rdata;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      {rst_n, wr_en, rd_en, cpu_idle, addr, wdata, pin_level} = 23'h0;
      err_total = 0;
      checks_done = 0;
      cyc = 0;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      rd(8'h01, d);
      check(d, 8'h40);
      check({5'h00, irq, watchdog_function, |module_pin_oe}, 8'h02);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, d);
         check(d, rows[i].x);
      end
      wr(8'h00, 8'h40);
      repeat (20) @(posedge clock);
      rd(8'h02, d);
      check(d, 8'h00);
      foreach (tb_n[k]) begin
         wr(8'h02, 8'h00);
         wr(8'h03, 8'h00);
         wr(8'h01, 8'(k << 1));
         wr(8'h00, 8'h40);
         repeat (94) @(posedge clock);
         wr(8'h00, 8'h00);
         rd(8'h02, d);
         rd(8'h03, e);
         check({7'h00, e == 8'h00 && d + 1 >= tb_n[k] && d <= tb_n[k] + 1},
            8'h01);
      end
      wr(8'h01, 8'h08);
      wr(8'h02, 8'hF0);
      wr(8'h00, 8'h40);
      rd(8'h02, d);
      repeat (20) @(posedge clock);
      rd(8'h03, e);
      check(e, 8'h00);
      rd(8'h02, e);
      check({7'h00, e > 8'h08 && e < 8'h20}, 8'h01);
      for (int s = 0; s < 2; s++) begin
         wr(8'h01, s[0] ? 8'h08 : 8'h09);
         wr(8'h02, 8'hF0);
         wr(8'h03, 8'hFF);
         repeat (60) @(posedge clock);
         rd(8'h00, d);
         check({6'h00, d[7], irq}, {6'h01, !s[0]});
         check({7'h00, global_irq_enable & array_irq_enable & irq},
            {7'h00, !s[0]});
         wr(8'h00, 8'h40);
      end
      cpu_idle <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         wr(8'h01, s[0] ? 8'h88 : 8'h08);
         rd(8'h02, d);
         repeat (10) @(posedge clock);
         rd(8'h02, e);
         check({7'h00, d == e}, {7'h00, s[0]});
      end
      cpu_idle <= 1'b0;
      wr(8'h00, 8'h00);
      wr(8'h02, 8'h34);
      wr(8'h03, 8'h12);
      for (int k = 1; k < 4; k++) begin
         wr(8'h04, 8'((k << 4) | 1));
         for (int v = 1; v >= 0; v--) begin
            wr(8'h00, 8'h00);
            pin_level[0] <= v[0];
            repeat (8) @(posedge clock);
            rd(8'h00, d);
            check({irq, d[6:0]}, {k[v], 6'h00, k[v]});
         end
      end
      rd(8'h05, d);
      rd(8'h06, e);
      check(d ^ e, 8'h26);
      wr(8'h07, 8'h42);
      wr(8'h08, 8'h80);
      rd(8'h07, d);
      check(d, 8'h02);
      check({6'h00, module_pin_oe[1], module_pin_out[1]}, 8'h02);
      wr(8'h09, 8'h80);
      rd(8'h07, d);
      check(d, 8'h42);
      wr(8'h0A, 8'h0C);
      wr(8'h0B, 8'h10);
      wr(8'h0C, 8'h00);
      wr(8'h02, 8'h00);
      wr(8'h03, 8'h00);
      wr(8'h00, 8'h40);
      repeat (30) @(posedge clock);
      rd(8'h00, d);
      check({5'h00, module_pin_out[2], module_pin_oe[2], d[2]}, 8'h07);
      give_verdict();
   end
endmodule // tb_counter_array_capture_compare
`default_nettype wire
